// >>> dps_defs.vh
// dual data pointer select: register offsets, bit positions, reset values
// assumes inclusion by the single design file of this block
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH

// special function register byte addresses
`define DPS_ADDR_AUX 8'hA2
`define DPS_ADDR_PTR_LO 8'h82
`define DPS_ADDR_PTR_HI 8'h83

// auxiliary control register bit positions
`define DPS_BIT_SEL 0
`define DPS_BIT_ZERO 2
// read mask that clears the constant-zero bit
`define DPS_AUX_ZERO_MASK 8'hFB

// reset values, zero byte and pointer increment step
`define DPS_AUX_RST 8'h00
`define DPS_PTR_RST 16'h0000
`define DPS_BYTE_ZERO 8'h00
`define DPS_PTR_ONE 16'h0001

// pointer operation codes
`define DPS_OP_NONE 3'h0
`define DPS_OP_INC 3'h1
`define DPS_OP_LOAD 3'h2
`define DPS_OP_CODE 3'h3
`define DPS_OP_XRD 3'h4
`define DPS_OP_XWR 3'h5
`define DPS_OP_JMP 3'h6
`define DPS_OP_AUXINC 3'h7

`endif

// >>> dps_pointer_select.v
// dual data pointer pair with selector in the auxiliary control register
// assumes a core on the same clock that issues one-cycle operation and
// register-access strobes; all inputs come from logic on ref_clk

`include "dps_defs.vh"

// What this block does
// - two independent 16-bit pointers, each giving full external address
// - auxiliary bit 0 selects pointer: 0 first, 1 second
// - auxiliary bit 2 ignores writes, always reads zero
// - incrementing auxiliary register toggles selector only, carry absorbed
// - pointer operations touch only the selected pointer
// - pointer increment adds one to full 16-bit selected pointer
// - immediate load writes 16-bit constant into selected pointer at once
// - code read addresses program memory at selected pointer plus accumulator
// - external read/write drive selected pointer as 16-bit address
// - indirect jump target is selected pointer plus accumulator
// - low and high bytes of selected pointer separately readable and writable
// - reset clears auxiliary register, selecting the first pointer
module dps_pointer_select (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] op_code,
  input wire [15:0] op_imm,
  input wire [7:0] accumulator,
  input wire [7:0] xdata_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_q,
  output reg sfr_hit_q,
  output reg [15:0] mem_addr_q,
  output reg code_rd_q,
  output reg xdata_rd_q,
  output reg xdata_wr_q,
  output reg [7:0] xdata_out_q,
  output reg jump_q,
  output reg [15:0] jump_target_q,
  output reg pointer_select_q
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [7:0] aux_q;
  reg [7:0] aux_d;
  wire [15:0] pointer_zero_q;
  wire [15:0] pointer_one_q;
  wire sel_one;
  wire [15:0] data_pointer;
  wire [15:0] ptr_plus_acc;
  wire [7:0] aux_rd;
  wire aux_wr;
  wire lo_wr;
  wire hi_wr;
  wire aux_hit;
  wire lo_hit;
  wire hi_hit;

  // ------------------------------------------------------------
  // operation decode
  // ------------------------------------------------------------
  wire op_inc;
  wire op_load;
  wire op_code_rd;
  wire op_xrd;
  wire op_xwr;
  wire op_jmp;
  wire op_aux_inc;

  // one decode wire per pointer operation
  assign op_inc = (op_code == `DPS_OP_INC);
  assign op_load = (op_code == `DPS_OP_LOAD);
  assign op_code_rd = (op_code == `DPS_OP_CODE);
  assign op_xrd = (op_code == `DPS_OP_XRD);
  assign op_xwr = (op_code == `DPS_OP_XWR);
  assign op_jmp = (op_code == `DPS_OP_JMP);
  assign op_aux_inc = (op_code == `DPS_OP_AUXINC);

  // register byte address decode
  assign aux_hit = (sfr_addr == `DPS_ADDR_AUX);
  assign lo_hit = (sfr_addr == `DPS_ADDR_PTR_LO);
  assign hi_hit = (sfr_addr == `DPS_ADDR_PTR_HI);
  assign aux_wr = sfr_wr && aux_hit;
  assign lo_wr = sfr_wr && lo_hit;
  assign hi_wr = sfr_wr && hi_hit;

  // ------------------------------------------------------------
  // selected pointer
  // ------------------------------------------------------------
  // selector picks pointer
  assign sel_one = aux_q[`DPS_BIT_SEL];
  assign data_pointer = sel_one ? pointer_one_q : pointer_zero_q;
  // pointer plus accumulator
  // zero-extended accumulator; carry out of bit 15 wraps, as an address must
  assign ptr_plus_acc = data_pointer + {`DPS_BYTE_ZERO, accumulator};
  assign aux_rd = aux_q & `DPS_AUX_ZERO_MASK;

  // ------------------------------------------------------------
  // auxiliary control register
  // ------------------------------------------------------------
  // next value from write or from an increment that toggles only the selector
  always @* begin
    aux_d = aux_q;
    if (aux_wr) begin
      aux_d = sfr_wdata;
    end else if (op_aux_inc) begin
      // increment toggles selector
      // the zero bit swallows the carry, so only the selector flips
      aux_d = aux_rd;
      aux_d[`DPS_BIT_SEL] = ~aux_rd[`DPS_BIT_SEL];
    end
    aux_d[`DPS_BIT_ZERO] = 1'b0;
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_q <= `DPS_AUX_RST;
    end else begin
      aux_q <= aux_d;
    end
  end

  // ------------------------------------------------------------
  // pointer pair
  // ------------------------------------------------------------
  // one generate copy per pointer; only the selected one updates
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
      reg [15:0] p_q;
      wire sel;
      // copy 0 follows a clear selector, copy 1 a set one
      assign sel = (gi == 0) ? ~sel_one : sel_one;
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          p_q <= `DPS_PTR_RST;
        end else if (sel) begin
          if (op_inc) begin
            p_q <= p_q + `DPS_PTR_ONE;
          end else if (op_load) begin
            p_q <= op_imm;
          end else if (lo_wr) begin
            p_q <= {p_q[15:8], sfr_wdata};
          end else if (hi_wr) begin
            p_q <= {sfr_wdata, p_q[7:0]};
          end
        end
      end
    end
  endgenerate

  // two independent pointers
  // each copy keeps its value while the other is in use
  assign pointer_zero_q = g_ptr[0].p_q;
  assign pointer_one_q = g_ptr[1].p_q;

  // ------------------------------------------------------------
  // memory address path and jump
  // ------------------------------------------------------------
  // registered strobes one cycle after the operation
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr_q <= `DPS_PTR_RST;
      code_rd_q <= 1'b0;
      xdata_rd_q <= 1'b0;
      xdata_wr_q <= 1'b0;
      xdata_out_q <= `DPS_BYTE_ZERO;
      jump_q <= 1'b0;
      jump_target_q <= `DPS_PTR_RST;
    end else begin
      // strobes are one-cycle pulses; the address holds between operations
      code_rd_q <= op_code_rd;
      xdata_rd_q <= op_xrd;
      xdata_wr_q <= op_xwr;
      jump_q <= op_jmp;
      if (op_code_rd) begin
        mem_addr_q <= ptr_plus_acc;
      end else if (op_xrd || op_xwr) begin
        mem_addr_q <= data_pointer;
      end
      if (op_xwr) begin
        xdata_out_q <= accumulator;
      end
      if (op_jmp) begin
        jump_target_q <= ptr_plus_acc;
      end
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata_q <= `DPS_BYTE_ZERO;
      sfr_hit_q <= 1'b0;
      pointer_select_q <= 1'b0;
    end else begin
      pointer_select_q <= aux_d[`DPS_BIT_SEL];
      // unmapped reads give zero data and no hit
      sfr_hit_q <= sfr_rd && (aux_hit || lo_hit || hi_hit);
      case (sfr_addr)
        `DPS_ADDR_AUX: sfr_rdata_q <= sfr_rd ? aux_rd : `DPS_BYTE_ZERO;
        `DPS_ADDR_PTR_LO: sfr_rdata_q <= sfr_rd ? data_pointer[7:0] : `DPS_BYTE_ZERO;
        `DPS_ADDR_PTR_HI: sfr_rdata_q <= sfr_rd ? data_pointer[15:8] : `DPS_BYTE_ZERO;
        default: sfr_rdata_q <= `DPS_BYTE_ZERO;
      endcase
    end
  end

endmodule // dps_pointer_select

// >>> dps_pointer_select_checker.sv
// checker for the pointer select block outputs
// assumes binding to the top design module
module dps_pointer_select_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] op_code,
  input wire [7:0] accumulator,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_q,
  input wire sfr_hit_q,
  input wire code_rd_q,
  input wire xdata_rd_q,
  input wire xdata_wr_q,
  input wire [7:0] xdata_out_q,
  input wire jump_q,
  input wire pointer_select_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // steps of selector write and of a lone jump
  sequence s_selw; sfr_wr && sfr_addr == 8'ha2; endsequence
  sequence s_jmp; op_code == 3'h6 ##1 op_code != 3'h6; endsequence
  property p_sel; s_selw |=> pointer_select_q == $past(sfr_wdata[0]); endproperty
  a_sel: assert property (p_sel) else $error("select write");
  property p_tog; op_code == 3'h7 && !sfr_wr |=> pointer_select_q != $past(pointer_select_q); endproperty
  a_tog: assert property (p_tog) else $error("select toggle");
  property p_zero; sfr_rd && sfr_addr == 8'ha2 |=> sfr_hit_q && !sfr_rdata_q[2]; endproperty
  a_zero: assert property (p_zero) else $error("bit two");
  property p_miss; sfr_rd && !(sfr_addr inside {8'ha2, 8'h82, 8'h83}) |=> !sfr_hit_q && sfr_rdata_q == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_xrd; op_code == 3'h4 |=> xdata_rd_q && !xdata_wr_q; endproperty
  a_xrd: assert property (p_xrd) else $error("xdata read");
  property p_xwr; op_code == 3'h5 |=> xdata_wr_q && xdata_out_q == $past(accumulator); endproperty
  a_xwr: assert property (p_xwr) else $error("xdata write");
  property p_code; op_code == 3'h3 |=> code_rd_q; endproperty
  a_code: assert property (p_code) else $error("code read");
  property p_jmp; s_jmp |-> jump_q ##1 !jump_q; endproperty
  a_jmp: assert property (p_jmp) else $error("jump pulse");
endmodule // dps_pointer_select_checker
bind dps_pointer_select dps_pointer_select_checker i_dps_pointer_select_checker (.*);

// >>> dps_xmem.sv
// external data memory model, keeps the last written byte
// assumes write strobes from the design on ref_clk
module dps_xmem (
  input wire ref_clk,
  input wire wr,
  input wire [7:0] din,
  output logic [7:0] last_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // take accumulator byte on write strobe
  always @(posedge ref_clk) begin
    if (wr) last_q <= din;
  end
endmodule // dps_xmem

// >>> dual_data_pointer_select_tb.sv
// self-checking bench for the pointer select block
// assumes the design, checker and memory model compiled before it
module dual_data_pointer_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0;
  logic [2:0] op_code = 0;
  logic [15:0] op_imm = 0;
  logic [7:0] accumulator = 0, sfr_addr = 0, sfr_wdata = 0;
  wire [7:0] sfr_rdata_q, xdata_out_q, last_q;
  wire [15:0] mem_addr_q, jump_target_q;
  wire sfr_hit_q, code_rd_q, xdata_rd_q, xdata_wr_q, jump_q, pointer_select_q;
  int err_count = 0, checks_done = 0;
  // rows: op, accumulator, constant, expected address or target
  logic [43:0] rows [10] = '{44'h200_12ff_0000, 44'h100_0000_0000, 44'h400_0000_1300, 44'h700_0000_0000,
    44'h200_ffff_0000, 44'h100_0000_0000, 44'h55a_0000_0000, 44'h700_0000_0000, 44'h310_0000_1310,
    44'h6f0_0000_13f0};
  dps_pointer_select i_dps_pointer_select (.*, .xdata_wdata(8'h00));
  dps_xmem i_dps_xmem (.ref_clk, .wr(xdata_wr_q), .din(xdata_out_q), .last_q);
  initial forever #12.5 ref_clk = ~ref_clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one register byte access, read data settled at the end
  task special_function_register(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr = 0;
    sfr_rd = 0;
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_b = 1;
    special_function_register(0, 8'ha2, 8'h00);
    chk(sfr_rdata_q, 16'h0000);
    chk(pointer_select_q, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      @(negedge ref_clk);
      {op_code, accumulator, op_imm} = rows[i][42:16];
      @(negedge ref_clk);
      op_code = 0;
      if (rows[i][42:40] inside {[3:6]}) chk(rows[i][42:40] == 6 ? jump_target_q : mem_addr_q, rows[i][15:0]);
    end
    chk(last_q, 16'h005a);
    $display("row test done");
    special_function_register(1, 8'ha2, 8'hff);
    special_function_register(0, 8'ha2, 8'h00);
    chk(sfr_rdata_q, 16'h00fb);
    special_function_register(1, 8'h82, 8'h34);
    special_function_register(1, 8'h83, 8'h12);
    special_function_register(0, 8'h83, 8'h00);
    chk(sfr_rdata_q, 16'h0012);
    special_function_register(1, 8'ha2, 8'h00);
    special_function_register(0, 8'h83, 8'h00);
    chk(sfr_rdata_q, 16'h0013);
    special_function_register(0, 8'h10, 8'h00);
    chk(sfr_hit_q, 16'h0000);
    special_function_register(1, 8'ha2, 8'h03);
    @(negedge ref_clk);
    op_code = 3'h7;
    @(negedge ref_clk);
    op_code = 0;
    special_function_register(0, 8'ha2, 8'h00);
    chk(sfr_rdata_q, 16'h0002);
    @(negedge ref_clk);
    sfr_wr = 1;
    sfr_addr = 8'ha2;
    sfr_wdata = 8'h01;
    @(negedge ref_clk);
    sfr_wr = 0;
    op_code = 3'h4;
    @(negedge ref_clk);
    op_code = 0;
    chk(mem_addr_q, 16'h1234);
    $display("awkward test done");
    conclude;
  end
  // watchdog
  initial begin
    #20us;
    err_count++;
    conclude;
  end
endmodule // dual_data_pointer_select_tb
